// ===== logic/script_loader.v
`timescale 1ns/100ps
`include "script_loader_regs.vh"
// What this block does
// - A low configuration-select pin at reset release puts the block in configuration mode.
// - In configuration mode the application run output stays low and only serial loading is serviced.
// - On entering configuration mode a text status line with version, script size and serial number is sent.
// - A received script with a matching checksum is committed to the store in place of the old one.
// - Byte 0x10 starts a download.
// - Each script byte arrives as two hex characters and is rebuilt into one binary byte.
// - Each pair is upper nibble first, upper-case letters for A to F.
// - Byte 0x0a ends the script data.
// - Four hex characters of checksum follow the line feed, most significant first.
// - The 16-bit sum of the script bytes is compared with the received checksum.
// - After a matching checksum a reply Download ok is sent and then a warm restart pulse is given; a mismatch gets Download error and no restart.
// - After reset the script store is empty.
// - The serial line runs at 9600 baud, 8 data bits, no parity, one stop bit.
module script_loader #(
  parameter CLK_HZ = `CLK_HZ,
  parameter BAUD = `BAUD_DEFAULT,
  parameter DEPTH = `STORE_DEPTH,
  parameter AW = `STORE_AW,
  parameter [7:0] FW_VER = 8'h12, // Arbitrary value
  parameter [31:0] SERIAL_NO = 32'h00000001 // Arbitrary value
) (
  input wire CORE_CLK_I,
  input wire SYS_RST_I,
  input wire CLK_EN_I,
  input wire CONFIG_SELECT_PIN_I,
  input wire RXD_I,
  input wire [AW-1:0] STORE_ADDR_I,
  output reg TXD_O,
  output reg TX_ENABLE_O,
  output reg CONFIG_MODE_O,
  output reg APP_RUN_O,
  output reg WARM_RESTART_O,
  output reg [AW:0] SCRIPT_LEN_O,
  output reg [7:0] STORE_DATA_O
);
localparam integer BIT_CYC = CLK_HZ / BAUD;
localparam integer HALF_CYC = BIT_CYC / 2;
localparam [1:0] M_BOOT = 2'h0, M_IDLE = 2'h1, M_DATA = 2'h2, M_SUM = 2'h3;
localparam [1:0] T_NONE = 2'h0, T_STAT = 2'h1, T_OK = 2'h2, T_ERR = 2'h3;
localparam [63:0] REPLY_HEAD = {8'h44, 8'h6f, 8'h77, 8'h6e, 8'h6c, 8'h6f, 8'h61, 8'h64};
localparam [8*`OK_LEN-1:0] OK_TEXT = {REPLY_HEAD, `CHR_SP, 8'h6f, 8'h6b, `CHR_CR, `CHR_LF};
localparam [8*`ERR_LEN-1:0] ERR_TEXT = {REPLY_HEAD, `CHR_SP, 8'h65, 8'h72, 8'h72, 8'h6f, 8'h72, `CHR_CR, `CHR_LF};

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function is_hex;
  input [7:0] c;
  begin
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  end
endfunction

function [3:0] hex_val;
  input [7:0] c;
  begin
    if (c <= 8'h39) begin
      hex_val = c[3:0];
    end else begin
      hex_val = c[3:0] + 4'h9;
    end
  end
endfunction

function [7:0] to_hex;
  input [3:0] n;
  begin
    if (n < 4'ha) begin
      to_hex = {4'h3, n};
    end else begin
      to_hex = {4'h0, n} + 8'h37;
    end
  end
endfunction

function [7:0] msg_char;
  input [1:0] kind;
  input [7:0] i;
  input [8*`STAT_LEN-1:0] stat;
  begin
    msg_char = `CHR_SP;
    if (kind == T_STAT && i < `STAT_LEN) begin
      msg_char = stat[8*(`STAT_LEN-8'd1-i) +: 8];
    end else if (kind == T_OK && i < `OK_LEN) begin
      msg_char = OK_TEXT[8*(`OK_LEN-8'd1-i) +: 8];
    end else if (kind == T_ERR && i < `ERR_LEN) begin
      msg_char = ERR_TEXT[8*(`ERR_LEN-8'd1-i) +: 8];
    end
  end
endfunction

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
reg [7:0] store [0:DEPTH-1];
reg [7:0] stage [0:DEPTH-1];
reg [AW:0] stage_len;
reg [AW:0] copy_idx;
reg copying;

// ----------------------------------------------------------------
// Receiver
// ----------------------------------------------------------------
reg rx_busy;
reg [15:0] rx_cnt;
reg [3:0] rx_bit;
reg [7:0] rx_sh;
reg rx_stb;
reg [7:0] rx_byte;

always @(posedge CORE_CLK_I) begin
  if (SYS_RST_I) begin
    rx_busy <= 1'b0;
    rx_cnt <= 16'h0000;
    rx_bit <= 4'h0;
    rx_sh <= 8'h00;
    rx_stb <= 1'b0;
    rx_byte <= 8'h00;
  end else if (CLK_EN_I) begin
    rx_stb <= 1'b0;
    if (!rx_busy) begin
      if (!RXD_I) begin
        rx_busy <= 1'b1;
        rx_cnt <= HALF_CYC[15:0];
        rx_bit <= 4'h0;
      end
    end else if (rx_cnt != 16'h0000) begin
      rx_cnt <= rx_cnt - 16'h0001;
    end else begin
      rx_cnt <= BIT_CYC[15:0] - 16'h0001;
      rx_bit <= rx_bit + 4'h1;
      if (rx_bit == 4'h0 && RXD_I) begin
        rx_busy <= 1'b0;
      end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
        rx_sh <= {RXD_I, rx_sh[7:1]};
      end else if (rx_bit == 4'h9) begin
        rx_busy <= 1'b0;
        rx_stb <= RXD_I;
        rx_byte <= rx_sh;
      end
    end
  end
end

// ----------------------------------------------------------------
// Transmitter and message sequencer
// ----------------------------------------------------------------
reg [1:0] tx_kind;
reg [7:0] tx_idx;
reg [15:0] tx_cnt;
reg [3:0] tx_bit;
reg [9:0] tx_sh;
reg tx_busy;
reg restart_due;
wire [7:0] tx_len = (tx_kind == T_STAT) ? `STAT_LEN : ((tx_kind == T_OK) ? `OK_LEN : `ERR_LEN);
wire [15:0] stat_size = {{(15-AW){1'b0}}, SCRIPT_LEN_O};
wire [8*`STAT_LEN-1:0] stat_text = {8'h56, to_hex(FW_VER[7:4]), to_hex(FW_VER[3:0]), `CHR_SP, 8'h53, 8'h3d,
  to_hex(stat_size[15:12]), to_hex(stat_size[11:8]), to_hex(stat_size[7:4]), to_hex(stat_size[3:0]), `CHR_SP,
  8'h4e, 8'h3d, to_hex(SERIAL_NO[31:28]), to_hex(SERIAL_NO[27:24]), to_hex(SERIAL_NO[23:20]),
  to_hex(SERIAL_NO[19:16]), to_hex(SERIAL_NO[15:12]), to_hex(SERIAL_NO[11:8]), to_hex(SERIAL_NO[7:4]),
  to_hex(SERIAL_NO[3:0]), `CHR_SP, `CHR_CR, `CHR_LF};

// ----------------------------------------------------------------
// Load control
// ----------------------------------------------------------------
reg [1:0] mode;
reg [3:0] hi_nib;
reg half;
reg [15:0] sum;
reg [15:0] rx_sum;
reg [1:0] sum_n;
wire hex_ok = is_hex(rx_byte);
wire [3:0] nib = hex_val(rx_byte);
wire [15:0] next_rx_sum = {rx_sum[11:0], nib};
reg start_tx;
reg [1:0] start_kind;

always @(posedge CORE_CLK_I) begin
  if (SYS_RST_I) begin
    mode <= M_BOOT;
    CONFIG_MODE_O <= 1'b0;
    APP_RUN_O <= 1'b0;
    half <= 1'b0;
    hi_nib <= 4'h0;
    sum <= 16'h0000;
    rx_sum <= 16'h0000;
    sum_n <= 2'h0;
    stage_len <= {(AW+1){1'b0}};
    SCRIPT_LEN_O <= {(AW+1){1'b0}};
    copying <= 1'b0;
    copy_idx <= {(AW+1){1'b0}};
    start_tx <= 1'b0;
    start_kind <= T_NONE;
    restart_due <= 1'b0;
  end else if (CLK_EN_I) begin
    start_tx <= 1'b0;
    if (copying) begin
      if (copy_idx == stage_len) begin
        copying <= 1'b0;
        SCRIPT_LEN_O <= stage_len;
      end else begin
        store[copy_idx[AW-1:0]] <= stage[copy_idx[AW-1:0]];
        copy_idx <= copy_idx + 1'b1;
      end
    end
    if (WARM_RESTART_O) begin
      restart_due <= 1'b0;
    end
    case (mode)
      M_BOOT: begin
        if (!APP_RUN_O) begin
          CONFIG_MODE_O <= ~CONFIG_SELECT_PIN_I;
          APP_RUN_O <= CONFIG_SELECT_PIN_I;
          if (!CONFIG_SELECT_PIN_I) begin
            mode <= M_IDLE;
            start_tx <= 1'b1;
            start_kind <= T_STAT;
          end
        end
      end
      M_IDLE: begin
        if (CONFIG_MODE_O && rx_stb && rx_byte == `CHR_START) begin
          mode <= M_DATA;
          half <= 1'b0;
          sum <= 16'h0000;
          stage_len <= {(AW+1){1'b0}};
        end
      end
      M_DATA: begin
        if (rx_stb) begin
          if (rx_byte == `CHR_LF && !half) begin
            mode <= M_SUM;
            sum_n <= 2'h0;
          end else if (!hex_ok) begin
            mode <= M_IDLE;
          end else if (!half) begin
            hi_nib <= nib;
            half <= 1'b1;
          end else begin
            half <= 1'b0;
            if (stage_len < DEPTH[AW:0]) begin
              stage[stage_len[AW-1:0]] <= {hi_nib, nib};
              stage_len <= stage_len + 1'b1;
            end
            sum <= sum + {8'h00, hi_nib, nib};
          end
        end
      end
      M_SUM: begin
        if (rx_stb) begin
          if (!hex_ok) begin
            mode <= M_IDLE;
          end else begin
            rx_sum <= next_rx_sum;
            sum_n <= sum_n + 2'h1;
            if (sum_n == 2'h3) begin
              mode <= M_IDLE;
              start_tx <= 1'b1;
              if (next_rx_sum == sum) begin
                start_kind <= T_OK;
                copying <= 1'b1;
                copy_idx <= {(AW+1){1'b0}};
                restart_due <= 1'b1;
              end else begin
                start_kind <= T_ERR;
              end
            end
          end
        end
      end
      default: mode <= M_BOOT;
    endcase
    if (WARM_RESTART_O) begin
      mode <= M_BOOT;
    end
  end
end

always @(posedge CORE_CLK_I) begin
  if (SYS_RST_I) begin
    TXD_O <= 1'b1;
    TX_ENABLE_O <= 1'b0;
    tx_kind <= T_NONE;
    tx_idx <= 8'h00;
    tx_cnt <= 16'h0000;
    tx_bit <= 4'h0;
    tx_sh <= 10'h3ff;
    tx_busy <= 1'b0;
    WARM_RESTART_O <= 1'b0;
    STORE_DATA_O <= 8'h00;
  end else if (CLK_EN_I) begin
    WARM_RESTART_O <= 1'b0;
    STORE_DATA_O <= store[STORE_ADDR_I];
    if (start_tx) begin
      tx_kind <= start_kind;
      tx_idx <= 8'h00;
    end else if (tx_busy) begin
      if (tx_cnt != 16'h0000) begin
        tx_cnt <= tx_cnt - 16'h0001;
      end else if (tx_bit == 4'h9) begin
        tx_busy <= 1'b0;
        TX_ENABLE_O <= 1'b0;
        tx_idx <= tx_idx + 8'h01;
      end else begin
        tx_cnt <= BIT_CYC[15:0] - 16'h0001;
        tx_bit <= tx_bit + 4'h1;
        TXD_O <= tx_sh[1];
        tx_sh <= {1'b1, tx_sh[9:1]};
      end
    end else if (tx_kind != T_NONE) begin
      if (tx_idx == tx_len) begin
        tx_kind <= T_NONE;
        WARM_RESTART_O <= restart_due && !copying;
      end else begin
        tx_sh <= {1'b1, msg_char(tx_kind, tx_idx, stat_text), 1'b0};
        TXD_O <= 1'b0;
        TX_ENABLE_O <= 1'b1;
        tx_busy <= 1'b1;
        tx_bit <= 4'h0;
        tx_cnt <= BIT_CYC[15:0] - 16'h0001;
      end
    end
  end
end

endmodule

// ===== logic/script_loader_regs.vh
`ifndef SCRIPT_LOADER_REGS_VH
`define SCRIPT_LOADER_REGS_VH
// Frame characters
`define CHR_START 8'h10
`define CHR_LF 8'h0a
`define CHR_CR 8'h0d
`define CHR_SP 8'h20
// Line rate
`define CLK_HZ 100000000
`define BAUD_DEFAULT 9600
// Store size
`define STORE_DEPTH 256
`define STORE_AW 8
// Status line length and reply lengths
`define STAT_LEN 8'd24
`define OK_LEN 8'd13
`define ERR_LEN 8'd16
`endif

// ===== verif/script_loader_monitor.sv
`timescale 1ns/100ps
// ----
// Port checks
// ----
module script_loader_monitor #(
  parameter AW = 8
) (
  input wire CORE_CLK_I,
  input wire SYS_RST_I,
  input wire CLK_EN_I,
  input wire CONFIG_SELECT_PIN_I,
  input wire RXD_I,
  input wire [AW-1:0] STORE_ADDR_I,
  input wire TXD_O,
  input wire TX_ENABLE_O,
  input wire CONFIG_MODE_O,
  input wire APP_RUN_O,
  input wire WARM_RESTART_O,
  input wire [AW:0] SCRIPT_LEN_O,
  input wire [7:0] STORE_DATA_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence s_release;
    $fell(SYS_RST_I);
  endsequence
  sequence s_low_bit;
    !TXD_O [*8];
  endsequence
  a_reset_state: assert property (s_release |-> TXD_O && !CONFIG_MODE_O && !APP_RUN_O && SCRIPT_LEN_O == 0)
    else $error("outputs not idle after reset");
  a_mode_select: assert property (s_release |=> CONFIG_MODE_O == !$past(CONFIG_SELECT_PIN_I))
    else $error("mode does not follow select pin");
  a_mode_exclusive: assert property (CONFIG_MODE_O |-> !APP_RUN_O)
    else $error("run and configuration together");
  a_run_silent: assert property (APP_RUN_O |-> TXD_O && !TX_ENABLE_O)
    else $error("serial output active in normal run");
  a_tx_in_config: assert property (TX_ENABLE_O |-> CONFIG_MODE_O)
    else $error("transmit outside configuration mode");
  a_line_idle: assert property (!TX_ENABLE_O |-> TXD_O)
    else $error("line not idle high");
  a_bit_width: assert property ($fell(TXD_O) |-> s_low_bit)
    else $error("low bit too short");
  a_restart_pulse: assert property (WARM_RESTART_O |-> !TX_ENABLE_O ##1 !WARM_RESTART_O)
    else $error("restart pulse wrong");
  a_len_config: assert property (!$stable(SCRIPT_LEN_O) |-> CONFIG_MODE_O)
    else $error("store length changed outside configuration");
endmodule
bind script_loader script_loader_monitor #(.AW(AW)) mon (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
  .CLK_EN_I(CLK_EN_I), .CONFIG_SELECT_PIN_I(CONFIG_SELECT_PIN_I), .RXD_I(RXD_I), .STORE_ADDR_I(STORE_ADDR_I),
  .TXD_O(TXD_O), .TX_ENABLE_O(TX_ENABLE_O), .CONFIG_MODE_O(CONFIG_MODE_O), .APP_RUN_O(APP_RUN_O),
  .WARM_RESTART_O(WARM_RESTART_O), .SCRIPT_LEN_O(SCRIPT_LEN_O), .STORE_DATA_O(STORE_DATA_O));

// ===== verif/host_uart.sv
`timescale 1ns/100ps
// ----
// Host serial model, 8N1, idle high
// ----
module host_uart #(
  parameter BIT = 16
) (
  input wire clk_i,
  input wire txd_i,
  output logic rxd_o
);
  logic [7:0] rx_q[$];
  initial rxd_o = 1'b1;
  task send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_i);
      rxd_o = f[i];
      repeat (BIT - 1) @(negedge clk_i);
    end
    repeat (gap) @(negedge clk_i);
  endtask
  always begin : rx_proc
    logic [7:0] d;
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      d[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    if (txd_i === 1'b1) rx_q.push_back(d);
  end
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk, rst, en, pin, rxd, txd, tx_en, cfg, run, wrst;
  logic [8:0] len;
  logic [7:0] addr, sdata;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_restart = 0;
  // ----
  // Design and host
  // ----
  script_loader #(.BAUD(6250000), .SERIAL_NO(32'h00012345)) uut (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .CLK_EN_I(en), .CONFIG_SELECT_PIN_I(pin), .RXD_I(rxd), .STORE_ADDR_I(addr), .TXD_O(txd),
    .TX_ENABLE_O(tx_en), .CONFIG_MODE_O(cfg), .APP_RUN_O(run), .WARM_RESTART_O(wrst),
    .SCRIPT_LEN_O(len), .STORE_DATA_O(sdata));
  host_uart #(.BIT(16)) host (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wrst === 1'b1) n_restart <= n_restart + 1;
    if (cyc == 40000) begin
      $display("ERROR at %0t: timeout", $time);
      n_errors = n_errors + 1;
      test_done();
    end
  end
  // ----
  // Helpers
  // ----
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_str(input string s);
    int k;
    for (int i = 0; i < s.len(); i++) begin
      for (k = 0; k < 4000 && host.rx_q.size() == 0; k++) @(posedge clk);
      chk({8'h00, host.rx_q.pop_front()}, {8'h00, s[i]});
    end
  endtask
  task reset_in(input logic level);
    @(negedge clk);
    rst = 1'b1;
    pin = level;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  function automatic [7:0] hx(input [3:0] n);
    hx = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  task send_frame(input logic [7:0] d[$], input logic [15:0] adj);
    logic [15:0] sum;
    sum = adj;
    host.send(8'h10, 0);
    foreach (d[i]) begin
      sum = sum + {8'h00, d[i]};
      host.send(hx(d[i][7:4]), 0);
      host.send(hx(d[i][3:0]), 0);
    end
    host.send(8'h0a, 0);
    for (int i = 12; i >= 0; i -= 4) host.send(hx(sum[i +: 4]), 0);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk({8'h00, sdata}, {8'h00, e});
  endtask
  // ----
  // Scenarios
  // ----
  task t_run;
    reset_in(1'b1);
    chk(16'(run), 16'h0001);
    chk(16'(cfg), 16'h0000);
    chk(16'(len), 16'h0000);
    repeat (400) @(negedge clk);
    chk(16'(host.rx_q.size()), 16'h0000);
  endtask
  task t_load;
    reset_in(1'b0);
    chk(16'(cfg), 16'h0001);
    chk_str("V12 S=0000 N=00012345 \r\n");
    host.send(8'h55, 40);
    send_frame('{8'h01, 8'h12, 8'h5a, 8'h23}, 16'h0000);
    chk_str("Download ok\r\n");
    chk_str("V12 S=0004 N=00012345 \r\n");
    chk(16'(n_restart), 16'h0001);
    chk(16'(len), 16'h0004);
    rd(8'h00, 8'h01);
    rd(8'h02, 8'h5a);
    rd(8'h03, 8'h23);
  endtask
  task t_bad;
    @(negedge clk);
    en = 1'b0;
    host.send(8'h10, 40);
    en = 1'b1;
    send_frame('{8'hff}, 16'h0001);
    chk_str("Download error\r\n");
    repeat (600) @(negedge clk);
    chk(16'(n_restart), 16'h0001);
    chk(16'(len), 16'h0004);
    rd(8'h00, 8'h01);
  endtask
  task t_abort;
    host.send(8'h10, 0);
    host.send(8'h30, 0);
    host.send(8'h61, 0);
    repeat (600) @(negedge clk);
    chk(16'(host.rx_q.size()), 16'h0000);
    send_frame('{8'hab, 8'hcd}, 16'h0000);
    chk_str("Download ok\r\n");
    chk_str("V12 S=0002 N=00012345 \r\n");
    rd(8'h01, 8'hcd);
  endtask
  task test_done;
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    en = 1'b1;
    pin = 1'b1;
    addr = 8'h00;
    t_run;
    t_load;
    t_bad;
    t_abort;
    test_done;
  end
endmodule
